//--- adc_alert_pkg.sv
// Shared constants and types for the limit alert status block
package adc_alert_pkg;
  // Register indices carried in the address field of a frame
  localparam logic [2:0] REG_CFG2 = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_LOW = 3'h4;
  localparam logic [2:0] REG_HIGH = 3'h5;
  // Frame layout
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_COUNT = 5'h10;
  localparam int WR_POS = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 12;
  localparam logic ADDR_PAD = 1'h0;
  // Status register fields
  localparam int NUM_CHAN = 4;
  localparam int CKSUM_BIT = 9;
  localparam int SETUP_BIT = 8;
  localparam logic [1:0] STATUS_RSVD = 2'h0;
  localparam logic [9:0] STATUS_RESET = 10'h000;
  localparam logic [9:0] READ_CLEAR_MASK = 10'h2ff;
  localparam logic [9:0] NO_CLEAR_MASK = 10'h000;
  // Limit registers and their expansion to 16 bits
  localparam logic [11:0] LOW_RESET = 12'h800;
  localparam logic [11:0] HIGH_RESET = 12'hfff;
  localparam logic [3:0] LOW_PAD = 4'h0;
  localparam logic [3:0] HIGH_PAD = 4'hf;
  // Second configuration register
  localparam logic [7:0] HARD_RESET_CODE = 8'hff;
  localparam logic [1:0] LANE_ALERT = 2'h1;
  localparam logic [11:0] CFG2_READ_DATA = 12'h000;
  localparam logic [15:0] IDLE_WORD = 16'h0000;
  // Serial port sequencer
  typedef enum logic [2:0] {
    PORT_IDLE = 3'b001,
    PORT_LOAD = 3'b010,
    PORT_SHIFT = 3'b100
  } port_state_e;
endpackage

//--- serial_frame_if.sv
// Word-level link between the serial pin port and the register core
`timescale 1ns/1ps
interface serial_frame_if;
  logic frame_start;
  logic word_valid;
  logic [15:0] rx_word;
  logic [15:0] tx_word;
  modport port (
    output frame_start,
    output word_valid,
    output rx_word,
    input tx_word
  );
  modport core (
    input frame_start,
    input word_valid,
    input rx_word,
    output tx_word
  );
endinterface

//--- serial_frame_port.sv
// Oversampled serial pin port: synchronises pins, frames 16-bit words
`timescale 1ns/1ps
module serial_frame_port
  import adc_alert_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Serial pins
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  output logic o_sdo,
  // Word side
  serial_frame_if.port bus
);
  typedef struct packed {
    port_state_e st;
    logic [1:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] sdi_s;
    logic sclk_prev;
    logic cs_prev;
    logic [4:0] cnt;
    logic [15:0] rx;
    logic [15:0] tx;
    logic output_lane_select;
    logic frame_start;
    logic word_valid;
  } port_s;

  port_s q;
  port_s d;
  logic sclk_rise;
  logic sclk_fall;

  // Bit 1 of each pair is the first stage and only feeds bit 0
  assign sclk_rise = q.sclk_s[0] & ~q.sclk_prev;
  assign sclk_fall = ~q.sclk_s[0] & q.sclk_prev;

  always_comb begin
    d = q;
    d.frame_start = 1'b0;
    d.word_valid = 1'b0;
    d.sclk_s = {i_sclk, q.sclk_s[1]};
    d.cs_s = {i_cs_n, q.cs_s[1]};
    d.sdi_s = {i_sdi, q.sdi_s[1]};
    d.sclk_prev = q.sclk_s[0];
    d.cs_prev = q.cs_s[0];
    unique case (q.st)
      PORT_IDLE: begin
        d.output_lane_select = 1'b0;
        if (!q.cs_s[0] && q.cs_prev) begin
          d.st = PORT_LOAD;
          d.frame_start = 1'b1;
          d.cnt = 5'h00;
        end
      end
      PORT_LOAD: begin
        // Core holds tx_word steady through the frame_start cycle, when it is latched here
        d.tx = bus.tx_word;
        d.output_lane_select = bus.tx_word[FRAME_BITS-1];
        d.st = PORT_SHIFT;
      end
      PORT_SHIFT: begin
        if (q.cs_s[0]) begin
          // A short frame is dropped without a word strobe
          d.word_valid = (q.cnt == FRAME_COUNT);
          d.st = PORT_IDLE;
        end else begin
          if (sclk_rise && q.cnt != FRAME_COUNT) begin
            d.rx = {q.rx[14:0], q.sdi_s[0]};
            d.cnt = q.cnt + 5'h01;
          end
          if (sclk_fall) begin
            d.tx = {q.tx[14:0], 1'b0};
            d.output_lane_select = q.tx[14];
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      q <= '{st: PORT_IDLE, sclk_s: 2'h0, cs_s: 2'h3, sdi_s: 2'h0,
             sclk_prev: 1'b0, cs_prev: 1'b1, cnt: 5'h00, rx: 16'h0000,
             tx: 16'h0000, output_lane_select: 1'b0, frame_start: 1'b0,
             word_valid: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign bus.frame_start = q.frame_start;
  assign bus.word_valid = q.word_valid;
  assign bus.rx_word = q.rx;
  assign o_sdo = q.output_lane_select;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  chk_word_full_frame: assert property (
    q.word_valid |-> $past(q.cnt) == FRAME_COUNT)
    else $error("word strobe without a full frame");
  chk_load_follows: assert property (
    q.frame_start |-> q.st == PORT_LOAD ##1 q.output_lane_select == $past(bus.tx_word[15]))
    else $error("first output bit not taken from tx word");
endmodule

//--- adc_limit_alert_status.sv
// Out-of-range and fault status registers behind the serial port
`timescale 1ns/1ps
module adc_limit_alert_status
  import adc_alert_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Serial register pins
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_serial_command_input,
  output logic o_primary_serial_output,
  // Conversion results
  input wire logic i_conv_valid,
  input wire logic [NUM_CHAN-1:0][15:0] i_conv_results,
  // Fault events
  input wire logic i_write_checksum_bad,
  input wire logic i_setup_load_fail,
  // Alert routing controls
  input wire logic i_alert_enable,
  input wire logic [1:0] i_output_lane_select,
  // Outputs
  output logic o_alert_n,
  output logic o_config_restart
);
  typedef struct packed {
    logic [9:0] flags;
    logic [11:0] low;
    logic [11:0] high;
    logic rd_pend;
    logic [2:0] rd_addr;
    logic restart;
    logic alert_n;
  } core_s;

  core_s q;
  core_s d;
  serial_frame_if bus ();
  logic [15:0] lower_cmp;
  logic [15:0] upper_cmp;
  logic [NUM_CHAN-1:0] over;
  logic [NUM_CHAN-1:0] under;
  logic [9:0] set_vec;
  logic [9:0] clr_mask;
  logic status_clr;
  logic cmd_wr;
  logic [2:0] cmd_addr;
  logic [11:0] cmd_data;
  logic hard_reset;

  serial_frame_port u_port (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_sclk(i_sclk),
    .i_cs_n(i_cs_n),
    .i_sdi(i_serial_command_input),
    .o_sdo(o_primary_serial_output),
    .bus(bus.port)
  );

  assign lower_cmp = {q.low, LOW_PAD};
  assign upper_cmp = {q.high, HIGH_PAD};

  genvar c;
  generate
    for (c = 0; c < NUM_CHAN; c++) begin : g_chan
      assign over[c] = i_conv_valid &&
                       (i_conv_results[c] > upper_cmp);
      assign under[c] = i_conv_valid &&
                        (i_conv_results[c] < lower_cmp);
      assign set_vec[2*c] = under[c];
      assign set_vec[2*c+1] = over[c];

      chk_over_sets: assert property (@(posedge i_clock)
        disable iff (i_reset) over[c] |=> q.flags[2*c+1])
        else $error("over flag not set after violation");
      chk_over_cause: assert property (@(posedge i_clock)
        disable iff (i_reset) $rose(q.flags[2*c+1]) |->
        $past(i_conv_valid && i_conv_results[c] > upper_cmp))
        else $error("over flag set without result above limit");
      chk_under_cause: assert property (@(posedge i_clock)
        disable iff (i_reset) $rose(q.flags[2*c]) |->
        $past(i_conv_valid && i_conv_results[c] < lower_cmp))
        else $error("under flag set without result below limit");
    end
  endgenerate

  assign set_vec[CKSUM_BIT] = i_write_checksum_bad;
  assign set_vec[SETUP_BIT] = i_setup_load_fail;

  assign cmd_wr = bus.rx_word[WR_POS];
  assign cmd_addr = bus.rx_word[ADDR_MSB:ADDR_LSB];
  assign cmd_data = bus.rx_word[11:0];
  assign hard_reset = bus.word_valid && cmd_wr && cmd_addr == REG_CFG2 &&
                      cmd_data[7:0] == HARD_RESET_CODE;
  // The status word is cleared as it is loaded for shifting out
  assign status_clr = bus.frame_start && q.rd_pend &&
                      q.rd_addr == REG_STATUS;
  // Setup error is outside the read-clear mask
  assign clr_mask = status_clr ? READ_CLEAR_MASK : NO_CLEAR_MASK;

  // Read-back word, held steady until the port latches it
  always_comb begin
    bus.tx_word = IDLE_WORD;
    if (q.rd_pend) begin
      unique case (q.rd_addr)
        REG_STATUS:
          bus.tx_word = {ADDR_PAD, REG_STATUS, STATUS_RSVD,
                         q.flags};
        REG_LOW:
          bus.tx_word = {ADDR_PAD, REG_LOW, q.low};
        REG_HIGH:
          bus.tx_word = {ADDR_PAD, REG_HIGH, q.high};
        default:
          bus.tx_word = {ADDR_PAD, REG_CFG2, CFG2_READ_DATA};
      endcase
    end
  end

  always_comb begin
    d = q;
    d.restart = 1'b0;
    // Set wins over the read clear so no event is lost
    d.flags = (q.flags & ~clr_mask) | set_vec;
    if (bus.frame_start) begin
      d.rd_pend = 1'b0;
    end
    if (bus.word_valid) begin
      if (cmd_wr) begin
        // Status writes fall through and alter no flag
        if (cmd_addr == REG_LOW) begin
          d.low = cmd_data;
        end else if (cmd_addr == REG_HIGH) begin
          d.high = cmd_data;
        end
      end else begin
        // Other addresses select conversion readback, not served here
        d.rd_pend = (cmd_addr == REG_CFG2) || (cmd_addr == REG_STATUS) ||
                    (cmd_addr == REG_LOW) ||
                    (cmd_addr == REG_HIGH);
        d.rd_addr = cmd_addr;
      end
    end
    if (hard_reset) begin
      // Defaults everywhere but rd_addr, and a same-cycle event still lands
      d.flags = STATUS_RESET | set_vec;
      d.low = LOW_RESET;
      d.high = HIGH_RESET;
      d.rd_pend = 1'b0;
      d.restart = 1'b1;
    end
    d.alert_n = ~(i_alert_enable && i_output_lane_select == LANE_ALERT &&
                  (|d.flags[7:0]));
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      q <= '{flags: STATUS_RESET, low: LOW_RESET, high: HIGH_RESET,
             rd_pend: 1'b0, rd_addr: REG_STATUS, restart: 1'b0,
             alert_n: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign o_alert_n = q.alert_n;
  assign o_config_restart = q.restart;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  sequence s_status_read_req;
    bus.word_valid && !cmd_wr && cmd_addr == REG_STATUS && !hard_reset;
  endsequence
  // The host may wait any time between frames, so the armed state is
  // tracked step by step rather than over a bounded window
  sequence s_status_armed;
    q.rd_pend && q.rd_addr == REG_STATUS;
  endsequence

  chk_cksum_sets: assert property (
    i_write_checksum_bad |=> q.flags[CKSUM_BIT])
    else $error("checksum error flag not set");
  chk_setup_sets: assert property (
    i_setup_load_fail |=> q.flags[SETUP_BIT])
    else $error("setup error flag not set");
  chk_setup_keeps: assert property (
    q.flags[SETUP_BIT] && !hard_reset |=> q.flags[SETUP_BIT])
    else $error("setup error flag cleared without hard reset");
  chk_hard_reset_defaults: assert property (
    hard_reset && !i_setup_load_fail |=> !q.flags[SETUP_BIT] &&
    q.low == LOW_RESET && q.high == HIGH_RESET && o_config_restart)
    else $error("hard reset did not restore defaults");
  chk_sticky_hold: assert property (
    $fell(q.flags[CKSUM_BIT]) || (|($past(q.flags[7:0]) & ~q.flags[7:0]))
    |-> $past(status_clr || hard_reset))
    else $error("sticky flag dropped without a status read");
  chk_set_wins: assert property (
    status_clr && over[0] |=> q.flags[1])
    else $error("violation lost in clearing cycle");
  chk_reserved_zero: assert property (
    q.rd_pend && q.rd_addr == REG_STATUS |-> bus.tx_word[11:10] == 2'h0)
    else $error("reserved status bits not zero");
  chk_status_write_ignored: assert property (
    bus.word_valid && cmd_wr && cmd_addr == REG_STATUS &&
    set_vec == 10'h000 && !status_clr |=> q.flags == $past(q.flags))
    else $error("status write altered flags");
  chk_read_arms: assert property (
    s_status_read_req |=> s_status_armed)
    else $error("status read request not armed");
  chk_read_holds: assert property (
    s_status_armed ##0 (!bus.frame_start && !bus.word_valid) |=>
    s_status_armed)
    else $error("armed status read dropped before next access");
  chk_read_returns: assert property (
    s_status_armed ##0 bus.frame_start |->
    bus.tx_word[15:12] == {ADDR_PAD, REG_STATUS} ##1 !q.rd_pend)
    else $error("status read request not served in next access");
  chk_alert_route: assert property (
    !o_alert_n |-> $past(i_alert_enable &&
    i_output_lane_select == LANE_ALERT))
    else $error("alert driven while not routed");
endmodule

//--- host_serial_model.sv
// Host processor model that frames register accesses on the serial pins
`timescale 1ns/1ps
module host_serial_model (
  // Clock
  input wire logic i_clock,
  // Serial pins
  input wire logic i_sdo,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdi
);
  // Serial clock stands still low outside frames
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  // One 16-bit frame: write bit, address, data, MSB first
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    r = 16'h0000;
    @(posedge i_clock);
    o_cs_n <= 1'b0;
    wait_clk(6);
    for (int i = 15; i >= 0; i--) begin
      o_sdi <= w[i];
      o_sclk <= 1'b0;
      wait_clk(4);
      o_sclk <= 1'b1;
      // Reply bit is sampled before this edge's updates land
      r[i] = i_sdo;
      wait_clk(4);
    end
    o_sclk <= 1'b0;
    wait_clk(4);
    o_cs_n <= 1'b1;
    // A released data line must not keep showing the last bit
    o_sdi <= ~w[0];
    wait_clk(6);
  endtask
endmodule

//--- tb_adc_limit_alert_status.sv
// Self-checking testbench for the limit alert status block
`timescale 1ns/1ps
module tb_adc_limit_alert_status
  import adc_alert_pkg::*;
;
  logic clock;
  logic reset;
  logic sclk;
  logic cs_n;
  logic serial_command_input;
  logic output_lane_select;
  logic conv_valid;
  logic [NUM_CHAN-1:0][15:0] conv_results;
  logic cksum_bad;
  logic setup_fail;
  logic alert_enable;
  logic [1:0] lane_select;
  logic alert_n;
  logic config_restart;
  logic [15:0] restarts = 16'h0000;
  int num_errors = 0;
  int comparisons = 0;

  adc_limit_alert_status u_dut (
    .i_clock(clock),
    .i_reset(reset),
    .i_sclk(sclk),
    .i_cs_n(cs_n),
    .i_serial_command_input(serial_command_input),
    .o_primary_serial_output(output_lane_select),
    .i_conv_valid(conv_valid),
    .i_conv_results(conv_results),
    .i_write_checksum_bad(cksum_bad),
    .i_setup_load_fail(setup_fail),
    .i_alert_enable(alert_enable),
    .i_output_lane_select(lane_select),
    .o_alert_n(alert_n),
    .o_config_restart(config_restart)
  );

  host_serial_model u_host (
    .i_clock(clock),
    .i_sdo(output_lane_select),
    .o_sclk(sclk),
    .o_cs_n(cs_n),
    .o_sdi(serial_command_input)
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  always @(posedge clock) begin
    if (config_restart === 1'b1) begin
      restarts <= restarts + 16'h0001;
    end
  end

  task automatic wrap_up;
    if (num_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] got,
                       input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask

  // Read request, then an address-0 frame that carries the reply
  task automatic rd(input logic [2:0] addr, input logic [15:0] exp);
    logic [15:0] r;
    u_host.xfer({1'b0, addr, 12'h000}, r);
    u_host.xfer(IDLE_WORD, r);
    check("register word", r, exp);
  endtask

  task automatic wr(input logic [2:0] addr, input logic [11:0] data);
    logic [15:0] r;
    u_host.xfer({1'b1, addr, data}, r);
  endtask

  task automatic conv(input logic [NUM_CHAN-1:0][15:0] res);
    @(posedge clock);
    conv_valid <= 1'b1;
    conv_results <= res;
    @(posedge clock);
    conv_valid <= 1'b0;
    @(posedge clock);
  endtask

  task automatic t_defaults;
    check("alert idle", {15'h0000, alert_n}, 16'h0001);
    rd(REG_LOW, 16'h4800);
    rd(REG_HIGH, {1'b0, REG_HIGH, 12'hfff});
    rd(REG_CFG2, 16'h2000);
    rd(REG_STATUS, 16'h3000);
  endtask

  // Each of the 8 limit flags alone, from one channel just past its limit
  task automatic t_limits;
    logic [NUM_CHAN-1:0][15:0] res;
    wr(REG_LOW, 12'h100);
    wr(REG_HIGH, 12'h200);
    rd(REG_LOW, 16'h4100);
    rd(REG_HIGH, 16'h5200);
    for (int k = 0; k < 8; k++) begin
      res = {NUM_CHAN{16'h1800}};
      res[k/2] = k[0] ? 16'h2010 : 16'h0fff;
      conv(res);
      rd(REG_STATUS, {8'h30, 8'h01 << k});
    end
    // Both boundaries themselves raise nothing
    conv({16'h200f, 16'h1000, 16'h200f, 16'h1000});
    rd(REG_STATUS, 16'h3000);
    conv({16'h1000, 16'h200f, 16'h1000, 16'h200f});
    rd(REG_STATUS, 16'h3000);
  endtask

  task automatic t_alert;
    lane_select <= 2'h0;
    conv({16'h1800, 16'h1800, 16'h1800, 16'hffff});
    check("alert lane 00", {15'h0000, alert_n}, 16'h0001);
    lane_select <= LANE_ALERT;
    alert_enable <= 1'b0;
    repeat (2) @(posedge clock);
    check("alert disabled", {15'h0000, alert_n}, 16'h0001);
    alert_enable <= 1'b1;
    repeat (2) @(posedge clock);
    check("alert on", {15'h0000, alert_n}, 16'h0000);
    rd(REG_STATUS, 16'h3002);
    check("alert cleared", {15'h0000, alert_n}, 16'h0001);
  endtask

  // Over-limit result lands in the very cycle the status reply is loaded
  task automatic t_set_wins;
    logic [15:0] r;
    u_host.xfer({1'b0, REG_STATUS, 12'h000}, r);
    fork
      u_host.xfer(IDLE_WORD, r);
      begin
        repeat (3) @(posedge clock);
        conv({16'h1800, 16'h1800, 16'h1800, 16'h2010});
      end
    join
    check("reply before event", r, 16'h3000);
    rd(REG_STATUS, 16'h3002);
  endtask

  task automatic t_faults;
    @(posedge clock);
    cksum_bad <= 1'b1;
    setup_fail <= 1'b1;
    @(posedge clock);
    cksum_bad <= 1'b0;
    setup_fail <= 1'b0;
    rd(REG_STATUS, 16'h3300);
    rd(REG_STATUS, 16'h3100);
    wr(REG_STATUS, 12'hfff);
    rd(REG_STATUS, 16'h3100);
    wr(REG_LOW, 12'h123);
    wr(REG_CFG2, {4'h0, HARD_RESET_CODE});
    check("restart pulses", restarts, 16'h0001);
    rd(REG_STATUS, 16'h3000);
    rd(REG_LOW, 16'h4800);
  endtask

  // Guard against a hang anywhere in the run
  initial begin
    #1ms;
    num_errors++;
    wrap_up();
  end

  initial begin
    reset = 1'b1;
    conv_valid = 1'b0;
    conv_results = '0;
    cksum_bad = 1'b0;
    setup_fail = 1'b0;
    alert_enable = 1'b1;
    lane_select = LANE_ALERT;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    t_defaults();
    t_limits();
    t_alert();
    t_set_wins();
    t_faults();
    wrap_up();
  end
endmodule
